// ==== shared/pcb_pkg.sv ====
package pcb_pkg;
	// link address of the device, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h2C;
	// system clock and link quarter bit time
	localparam int CLK_NS = 4;
	localparam int LINK_QTR_NS = 32;
	localparam int HOST_QTR_CYC = (LINK_QTR_NS + CLK_NS - 1) / CLK_NS;
	// supply hysteresis in counts of the newer scale
	localparam int SUPPLY_HYST_MV = 1000;
	localparam int SUPPLY_STEP_MV = 61;
	localparam logic [10:0] SUPPLY_HYST =
		11'(SUPPLY_HYST_MV / SUPPLY_STEP_MV);
	// register array layout
	localparam int NREG = 25;
	localparam logic [15:0] REG_OFF [NREG] = '{
		16'h008C, 16'h00BB, 16'h00BC, 16'h0106, 16'h0107,
		16'h0110, 16'h0111, 16'h0112, 16'h0318, 16'h100E,
		16'h1010, 16'h1144, 16'h1160, 16'h12FE, 16'h1300,
		16'h1302, 16'h1318, 16'h138C, 16'h138E, 16'h1390,
		16'h1392, 16'h1394, 16'h1396, 16'h1398, 16'h139A};
	localparam logic [15:0] REG_RST [NREG] = '{
		16'h0020, 16'h03E7, 16'h02E5, 16'h0226, 16'h560A,
		16'h0000, 16'h0000, 16'h0FFF, 16'h0000, 16'h0208,
		16'h0208, 16'h0000, 16'h0015, 16'h03BC, 16'h0313,
		16'h02B0, 16'h0000, 16'h8700, 16'h10E0, 16'h0BB8,
		16'h0898, 16'h07D0, 16'h05DC, 16'h04B0, 16'h03E8};
	localparam logic [15:0] REG_MASK [NREG] = '{
		16'h003F, 16'h03FF, 16'h03FF, 16'hFFFF, 16'hFFFF,
		16'h0FFF, 16'h0FFF, 16'h0FFF, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h03FF, 16'h03FF,
		16'h03FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	// array indices of registers with own behaviour
	localparam logic [4:0] I_TOL = 5'd0;
	localparam logic [4:0] I_VHL = 5'd1;
	localparam logic [4:0] I_GUARD = 5'd3;
	localparam logic [4:0] I_BLEG = 5'd4;
	localparam logic [4:0] I_ALLOC = 5'd5;
	localparam logic [4:0] I_CLASS = 5'd6;
	localparam logic [4:0] I_AUTO = 5'd7;
	localparam logic [4:0] I_TOF = 5'd9;
	localparam logic [4:0] I_TOT = 5'd10;
	localparam logic [4:0] I_EVT = 5'd11;
	localparam logic [4:0] I_FLAGS = 5'd12;
	localparam logic [4:0] I_VH = 5'd13;
	localparam logic [4:0] I_VLT = 5'd14;
	localparam logic [4:0] I_VLF = 5'd15;
	localparam logic [4:0] I_SYNC = 5'd16;
	localparam logic [4:0] I_BUD0 = 5'd17;
	// mode change key register
	localparam logic [15:0] KEY_OFF = 16'h139E;
	localparam logic [7:0] KEY_MATCH = 8'hDC;
	localparam logic [2:0] MODE_STANDALONE = 3'h0;
	localparam logic [2:0] MODE_MACRO = 3'h1;
	localparam logic [2:0] MODE_MANUAL = 3'h2;
	localparam logic [2:0] MODE_CFG = 3'h3;
	localparam logic [2:0] MODE_RST = MODE_CFG;
	// protected space and port shutdown command
	localparam logic [15:0] PROT_BASE = 16'h1000;
	localparam logic [15:0] SHUT_OFF = 16'h1332;
	localparam logic [15:0] SHUT_ALL = 16'h03FF;
	localparam logic [15:0] SHUT_NONE = 16'h0000;
	// one-hot sync event codes
	localparam logic [15:0] SYNC_DETECT = 16'h0001;
	localparam logic [15:0] SYNC_STARTUP = 16'h0002;
	localparam logic [15:0] SYNC_BUDGET = 16'h0004;
	localparam logic [15:0] SYNC_READ_IND = 16'h0008;
	localparam logic [15:0] SYNC_MACRO = 16'h0010;
	localparam logic [15:0] SYNC_MODE = 16'h0020;
	localparam logic [15:0] SYNC_IRQ_OUT = 16'h0040;
	localparam logic [15:0] SYNC_PM_IND = 16'h0080;
	localparam logic [15:0] SYNC_MASTERS = 16'h0100;
	// field positions
	localparam int FLAG_PM_DYN = 6;
	localparam int FLAG_CAP_DIS = 2;
	localparam logic [11:0] ALLOC_DYN = 12'hFFF;
	localparam logic [11:0] ALLOC_IGN = 12'h000;
	// device link slave states
	typedef enum logic [2:0] {
		SL_IDLE = 3'b001,
		SL_RX = 3'b010,
		SL_TX = 3'b100
	} pcb_sl_t;
	// host link master states
	typedef enum logic [3:0] {
		HM_IDLE = 4'b0001,
		HM_START = 4'b0010,
		HM_BIT = 4'b0100,
		HM_STOP = 4'b1000
	} pcb_hm_t;
	// register lookup: bit 5 hit, bits 4:0 index
	function automatic logic [5:0] reg_find(input logic [15:0] a);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < NREG; i++) begin
			if (a == REG_OFF[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction
endpackage

// ==== shared/pcb_link_if.sv ====
`timescale 1ns/1ps
interface pcb_link_if;
	logic scl; // link clock, made by host
	logic host_sda_oe; // host pulls data low
	logic dev_sda_oe; // device pulls data low
	logic sda; // resolved open-drain data level
	assign sda = !(host_sda_oe || dev_sda_oe);
	modport host (output scl, output host_sda_oe, input sda);
	modport dev (input scl, input sda, output dev_sda_oe);
endinterface // pcb_link_if

// ==== logic/pcb_dev.sv ====
`timescale 1ns/1ps
module pcb_dev (
	input wire logic sys_clk,
	input wire logic rst_n,
	pcb_link_if.dev link,
	input wire logic [2:0] power_good,
	input wire logic [9:0] supply_level,
	input wire logic [9:0] supply_level_legacy,
	input wire logic [15:0] total_power,
	output logic [2:0] op_mode,
	output logic config_active,
	output logic [5:0] ovl_timer_legacy,
	output logic [15:0] ovl_timer_f,
	output logic [15:0] ovl_timer_t,
	output logic [15:0] sync_type,
	output logic [15:0] event_sync,
	output logic [15:0] budget_active,
	output logic alloc_dynamic,
	output logic alloc_ignore,
	output logic [11:0] class_calc,
	output logic [11:0] auto_calc,
	output logic pm_dynamic,
	output logic legacy_cap_dis,
	output logic ports_off,
	output logic under_t,
	output logic under_f,
	output logic no_new_port
);
	logic [1:0] scl_sy_ff; // link clock synchroniser
	logic [1:0] sda_sy_ff; // link data synchroniser
	logic [2:0] pg_s1_ff; // power-good first stage
	logic [2:0] pg_s2_ff; // power-good second stage
	logic scl_d_ff; // previous synced clock
	logic sda_d_ff; // previous synced data
	logic scl_s;
	logic sda_s;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	pcb_pkg::pcb_sl_t st_ff; // slave state
	logic [3:0] cnt_ff; // bits taken in this byte
	logic [2:0] idx_ff; // byte number in frame
	logic ack_ff; // inside ninth bit slot
	logic ack_ok_ff; // device acks current byte
	logic [6:0] shift_ff; // received bits
	logic [7:0] rx_byte;
	logic [15:0] addr_ff; // register address
	logic [7:0] dhi_ff; // write data upper byte
	logic [15:0] rd_ff; // word being returned
	logic [7:0] tx_byte;
	logic sda_oe_ff; // pull data low
	logic wr_stb_ff; // word write pulse
	logic [15:0] wr_data_ff; // word to write
	logic [15:0] regs_ff [pcb_pkg::NREG]; // register array
	logic [5:0] hit; // lookup of addr_ff
	logic wr_ok;
	logic [15:0] rd_val;
	logic [2:0] mode_ff; // applied operating mode
	logic cfg_ff; // config mode active
	logic pend_ff; // mode change armed
	logic [2:0] pend_mode_ff; // mode waiting for syncs
	logic seen_sy_ff; // mode sync written
	logic seen_ev_ff; // mode event written
	logic key_wr;
	logic ovr_ff; // newer overvoltage state
	logic ports_off_ff;
	logic under_t_ff;
	logic under_f_ff;
	logic nxt_ovr;
	logic nxt_under_t;
	logic nxt_under_f;
	logic no_new_ff;
	logic [15:0] bud_ff;
	logic alloc_dyn_ff;
	logic alloc_ign_ff;
	logic [10:0] sup_w; // widened supply sample

	// two flip-flops on the link and power-good inputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sy_ff <= 2'h3;
			sda_sy_ff <= 2'h3;
			pg_s1_ff <= 3'h0;
			pg_s2_ff <= 3'h0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_sy_ff <= {scl_sy_ff[0], link.scl};
			sda_sy_ff <= {sda_sy_ff[0], link.sda};
			pg_s1_ff <= power_good;
			pg_s2_ff <= pg_s1_ff;
			scl_d_ff <= scl_sy_ff[1];
			sda_d_ff <= sda_sy_ff[1];
		end
	end

	// edges and frame conditions
	assign scl_s = scl_sy_ff[1];
	assign sda_s = sda_sy_ff[1];
	assign rise = scl_s && !scl_d_ff;
	assign fall = !scl_s && scl_d_ff;
	assign start_c = scl_s && scl_d_ff && sda_d_ff && !sda_s;
	assign stop_c = scl_s && scl_d_ff && !sda_d_ff && sda_s;
	assign rx_byte = {shift_ff, sda_s};
	assign tx_byte = (idx_ff == 3'd1) ? rd_ff[15:8] : rd_ff[7:0];

	// link slave: bytes, acks and returned bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= pcb_pkg::SL_IDLE;
			cnt_ff <= 4'h0;
			idx_ff <= 3'h0;
			ack_ff <= 1'b0;
			ack_ok_ff <= 1'b0;
			shift_ff <= 7'h00;
			addr_ff <= 16'h0000;
			dhi_ff <= 8'h00;
			rd_ff <= 16'h0000;
			sda_oe_ff <= 1'b0;
		end else if (start_c) begin
			// start or repeated start, address kept
			st_ff <= pcb_pkg::SL_RX;
			cnt_ff <= 4'h0;
			idx_ff <= 3'h0;
			ack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (stop_c) begin
			st_ff <= pcb_pkg::SL_IDLE;
			ack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (st_ff != pcb_pkg::SL_IDLE) begin
			if (rise && ack_ff) begin
				// host nack after a returned byte ends it
				if (st_ff == pcb_pkg::SL_TX && idx_ff >= 3'd2 && sda_s) begin
					st_ff <= pcb_pkg::SL_IDLE;
				end
			end else if (rise) begin
				cnt_ff <= cnt_ff + 4'h1;
				shift_ff <= rx_byte[6:0];
				if (cnt_ff == 4'h7) begin
					if (idx_ff != 3'd5) begin
						idx_ff <= idx_ff + 3'd1;
					end
					unique case (idx_ff)
					3'd0: begin
						// device address byte
						ack_ok_ff <= (rx_byte[7:1] == pcb_pkg::DEV_ADDR);
						if (rx_byte[7:1] != pcb_pkg::DEV_ADDR) begin
							st_ff <= pcb_pkg::SL_IDLE;
						end else if (rx_byte[0]) begin
							st_ff <= pcb_pkg::SL_TX;
							rd_ff <= rd_val;
						end
					end
					3'd1: begin
						addr_ff[15:8] <= rx_byte;
					end
					3'd2: begin
						addr_ff[7:0] <= rx_byte;
					end
					3'd3: begin
						dhi_ff <= rx_byte;
					end
					default: begin
						// bytes past one word are refused
						ack_ok_ff <= (st_ff == pcb_pkg::SL_RX) && (idx_ff == 3'd4);
					end
					endcase
					if (st_ff == pcb_pkg::SL_TX) begin
						ack_ok_ff <= 1'b0;
					end
				end
			end else if (fall && ack_ff) begin
				// ack slot over, first returned bit
				ack_ff <= 1'b0;
				cnt_ff <= 4'h0;
				sda_oe_ff <= (st_ff == pcb_pkg::SL_TX) && !tx_byte[7];
			end else if (fall && cnt_ff == 4'h8) begin
				ack_ff <= 1'b1;
				sda_oe_ff <= ack_ok_ff;
			end else if (fall && st_ff == pcb_pkg::SL_TX) begin
				sda_oe_ff <= !tx_byte[3'd7 - cnt_ff[2:0]];
			end
		end
	end

	// write pulse when the low data byte lands
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_stb_ff <= 1'b0;
			wr_data_ff <= 16'h0000;
		end else begin
			wr_stb_ff <= st_ff == pcb_pkg::SL_RX && !ack_ff && rise &&
				cnt_ff == 4'h7 && idx_ff == 3'd4 && !start_c && !stop_c;
			if (rise && cnt_ff == 4'h7 && idx_ff == 3'd4) begin
				wr_data_ff <= {dhi_ff, rx_byte};
			end
		end
	end

	// decode and write gating
	assign hit = pcb_pkg::reg_find(addr_ff);
	assign wr_ok = hit[5] && !addr_ff[0] &&
		(addr_ff < pcb_pkg::PROT_BASE || cfg_ff ||
		hit[4:0] == pcb_pkg::I_SYNC || hit[4:0] == pcb_pkg::I_EVT);

	// register array with per-register width masks
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < pcb_pkg::NREG; i++) begin
				regs_ff[i] <= pcb_pkg::REG_RST[i];
			end
		end else if (wr_stb_ff && wr_ok) begin
			regs_ff[hit[4:0]] <= wr_data_ff & pcb_pkg::REG_MASK[hit[4:0]];
		end
	end

	// read word: key shows applied mode, odd reads zero
	always_comb begin
		rd_val = 16'h0000;
		if (addr_ff[0]) begin
			rd_val = 16'h0000;
		end else if (addr_ff == pcb_pkg::KEY_OFF) begin
			rd_val = {13'h0000, mode_ff};
		end else if (hit[5]) begin
			rd_val = regs_ff[hit[4:0]];
		end
	end

	// mode change: key arms, both mode syncs apply
	assign key_wr = wr_stb_ff && addr_ff == pcb_pkg::KEY_OFF;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= pcb_pkg::MODE_RST;
			cfg_ff <= 1'b1;
			pend_ff <= 1'b0;
			pend_mode_ff <= pcb_pkg::MODE_STANDALONE;
			seen_sy_ff <= 1'b0;
			seen_ev_ff <= 1'b0;
		end else if (key_wr && wr_data_ff[15:8] == pcb_pkg::KEY_MATCH) begin
			pend_mode_ff <= wr_data_ff[2:0];
			pend_ff <= 1'b1;
			seen_sy_ff <= 1'b0;
			seen_ev_ff <= 1'b0;
		end else if (pend_ff && seen_sy_ff && seen_ev_ff) begin
			mode_ff <= pend_mode_ff;
			cfg_ff <= pend_mode_ff == pcb_pkg::MODE_CFG;
			pend_ff <= 1'b0;
		end else if (pend_ff && wr_stb_ff && wr_data_ff == pcb_pkg::SYNC_MODE) begin
			if (addr_ff == pcb_pkg::REG_OFF[pcb_pkg::I_SYNC]) begin
				seen_sy_ff <= 1'b1;
			end
			if (addr_ff == pcb_pkg::REG_OFF[pcb_pkg::I_EVT]) begin
				seen_ev_ff <= 1'b1;
			end
		end
	end

	// supply thresholds with hysteresis
	assign sup_w = {1'b0, supply_level};
	always_comb begin
		nxt_ovr = ovr_ff;
		nxt_under_t = under_t_ff;
		nxt_under_f = under_f_ff;
		if (supply_level > regs_ff[pcb_pkg::I_VH][9:0]) begin
			nxt_ovr = 1'b1;
		end else if (sup_w + pcb_pkg::SUPPLY_HYST <
			{1'b0, regs_ff[pcb_pkg::I_VH][9:0]}) begin
			nxt_ovr = 1'b0;
		end
		if (supply_level < regs_ff[pcb_pkg::I_VLT][9:0]) begin
			nxt_under_t = 1'b1;
		end else if (sup_w > {1'b0, regs_ff[pcb_pkg::I_VLT][9:0]} +
			pcb_pkg::SUPPLY_HYST) begin
			nxt_under_t = 1'b0;
		end
		if (supply_level < regs_ff[pcb_pkg::I_VLF][9:0]) begin
			nxt_under_f = 1'b1;
		end else if (sup_w > {1'b0, regs_ff[pcb_pkg::I_VLF][9:0]} +
			pcb_pkg::SUPPLY_HYST) begin
			nxt_under_f = 1'b0;
		end
	end

	// monitors, budget pick and allocation decode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovr_ff <= 1'b0;
			ports_off_ff <= 1'b0;
			under_t_ff <= 1'b0;
			under_f_ff <= 1'b0;
			no_new_ff <= 1'b0;
			bud_ff <= pcb_pkg::REG_RST[pcb_pkg::I_BUD0];
			alloc_dyn_ff <= 1'b0;
			alloc_ign_ff <= 1'b1;
		end else begin
			ovr_ff <= nxt_ovr;
			ports_off_ff <= nxt_ovr || supply_level_legacy >
				regs_ff[pcb_pkg::I_VHL][9:0];
			under_t_ff <= nxt_under_t;
			under_f_ff <= nxt_under_f;
			no_new_ff <= ({1'b0, total_power} +
				{1'b0, regs_ff[pcb_pkg::I_GUARD]}) >
				{1'b0, regs_ff[pcb_pkg::I_BLEG]};
			bud_ff <= regs_ff[pcb_pkg::I_BUD0 + {2'b00, pg_s2_ff}];
			alloc_dyn_ff <= regs_ff[pcb_pkg::I_ALLOC][11:0] ==
				pcb_pkg::ALLOC_DYN;
			alloc_ign_ff <= regs_ff[pcb_pkg::I_ALLOC][11:0] ==
				pcb_pkg::ALLOC_IGN;
		end
	end

	// outputs straight from flip-flops
	assign link.dev_sda_oe = sda_oe_ff;
	assign op_mode = mode_ff;
	assign config_active = cfg_ff;
	assign ovl_timer_legacy = regs_ff[pcb_pkg::I_TOL][5:0];
	assign ovl_timer_f = regs_ff[pcb_pkg::I_TOF];
	assign ovl_timer_t = regs_ff[pcb_pkg::I_TOT];
	assign sync_type = regs_ff[pcb_pkg::I_SYNC];
	assign event_sync = regs_ff[pcb_pkg::I_EVT];
	assign budget_active = bud_ff;
	assign alloc_dynamic = alloc_dyn_ff;
	assign alloc_ignore = alloc_ign_ff;
	assign class_calc = regs_ff[pcb_pkg::I_CLASS][11:0];
	assign auto_calc = regs_ff[pcb_pkg::I_AUTO][11:0];
	assign pm_dynamic = regs_ff[pcb_pkg::I_FLAGS][pcb_pkg::FLAG_PM_DYN];
	assign legacy_cap_dis =
		regs_ff[pcb_pkg::I_FLAGS][pcb_pkg::FLAG_CAP_DIS];
	assign ports_off = ports_off_ff;
	assign under_t = under_t_ff;
	assign under_f = under_f_ff;
	assign no_new_port = no_new_ff;
endmodule // pcb_dev

// ==== logic/pcb_host.sv ====
`timescale 1ns/1ps
module pcb_host (
	input wire logic sys_clk,
	input wire logic rst_n,
	pcb_link_if.host link,
	input wire logic req,
	input wire logic req_write,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [15:0] rdata,
	output logic ports_disabled
);
	logic [1:0] sda_sy_ff; // data synchroniser
	logic sda_s;
	logic [3:0] qcnt_ff; // quarter divider
	logic tick;
	pcb_pkg::pcb_hm_t st_ff; // master state
	logic [1:0] q_ff; // quarter within bit
	logic [3:0] b_ff; // bit within byte, 8 is ack
	logic [2:0] n_ff; // byte number
	logic wr_ff;
	logic [15:0] addr_ff;
	logic [15:0] wd_ff;
	logic [15:0] rx_ff; // received word
	logic scl_ff;
	logic oe_ff;
	logic nack_ff;
	logic done_ff;
	logic busy_ff;
	logic [15:0] rdata_ff;
	logic pdis_ff; // ports known turned off
	logic [7:0] cur; // byte being sent
	logic rxb; // byte is being received
	logic refuse;

	// two flip-flops on the data pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_sy_ff <= 2'h3;
		end else begin
			sda_sy_ff <= {sda_sy_ff[0], link.sda};
		end
	end
	assign sda_s = sda_sy_ff[1];

	// quarter bit divider, runs only in a frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			qcnt_ff <= 4'h0;
		end else if (st_ff == pcb_pkg::HM_IDLE || tick) begin
			qcnt_ff <= 4'h0;
		end else begin
			qcnt_ff <= qcnt_ff + 4'h1;
		end
	end
	assign tick = qcnt_ff == 4'(pcb_pkg::HOST_QTR_CYC - 1);

	// byte sequence of a frame
	always_comb begin
		unique case (n_ff)
		3'd0: cur = {pcb_pkg::DEV_ADDR, 1'b0};
		3'd1: cur = addr_ff[15:8];
		3'd2: cur = addr_ff[7:0];
		3'd3: cur = wr_ff ? wd_ff[15:8] : {pcb_pkg::DEV_ADDR, 1'b1};
		default: cur = wd_ff[7:0];
		endcase
	end
	assign rxb = !wr_ff && n_ff >= 3'd4;
	// odd address or config entry with ports live
	assign refuse = req_addr[0] ||
		(req_write && req_addr == pcb_pkg::KEY_OFF &&
		req_wdata[15:8] == pcb_pkg::KEY_MATCH &&
		req_wdata[2:0] == pcb_pkg::MODE_CFG && !pdis_ff);

	// link master: start, bits, acks, stop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= pcb_pkg::HM_IDLE;
			q_ff <= 2'h0;
			b_ff <= 4'h0;
			n_ff <= 3'h0;
			wr_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wd_ff <= 16'h0000;
			rx_ff <= 16'h0000;
			scl_ff <= 1'b1;
			oe_ff <= 1'b0;
			nack_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			pdis_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			unique case (st_ff)
			pcb_pkg::HM_IDLE: begin
				if (req && refuse) begin
					nack_ff <= 1'b1;
					done_ff <= 1'b1;
				end else if (req) begin
					st_ff <= pcb_pkg::HM_START;
					busy_ff <= 1'b1;
					nack_ff <= 1'b0;
					q_ff <= 2'h0;
					n_ff <= 3'h0;
					wr_ff <= req_write;
					addr_ff <= req_addr;
					wd_ff <= req_wdata;
				end
			end
			pcb_pkg::HM_START: begin
				if (tick) begin
					q_ff <= q_ff + 2'h1;
					unique case (q_ff)
					2'd0: oe_ff <= 1'b0;
					2'd1: scl_ff <= 1'b1;
					2'd2: oe_ff <= 1'b1;
					default: begin
						scl_ff <= 1'b0;
						b_ff <= 4'h0;
						st_ff <= pcb_pkg::HM_BIT;
					end
					endcase
				end
			end
			pcb_pkg::HM_BIT: begin
				if (tick) begin
					q_ff <= q_ff + 2'h1;
					unique case (q_ff)
					2'd0: begin
						// ack the high byte, nack the low byte
						if (rxb) begin
							oe_ff <= b_ff == 4'h8 && n_ff == 3'd4;
						end else begin
							oe_ff <= b_ff != 4'h8 && !cur[3'd7 - b_ff[2:0]];
						end
					end
					2'd1: scl_ff <= 1'b1;
					2'd2: begin
						if (b_ff != 4'h8 && rxb) begin
							rx_ff <= {rx_ff[14:0], sda_s};
						end else if (b_ff == 4'h8 && !rxb && sda_s) begin
							nack_ff <= 1'b1;
						end
					end
					default: begin
						scl_ff <= 1'b0;
						b_ff <= (b_ff == 4'h8) ? 4'h0 : b_ff + 4'h1;
						if (b_ff == 4'h8) begin
							n_ff <= n_ff + 3'd1;
							if (nack_ff || (wr_ff && n_ff == 3'd4) ||
								n_ff == 3'd5) begin
								st_ff <= pcb_pkg::HM_STOP;
							end else if (!wr_ff && n_ff == 3'd2) begin
								st_ff <= pcb_pkg::HM_START;
							end
						end
					end
					endcase
				end
			end
			pcb_pkg::HM_STOP: begin
				if (tick) begin
					q_ff <= q_ff + 2'h1;
					unique case (q_ff)
					2'd0: oe_ff <= 1'b1;
					2'd1: scl_ff <= 1'b1;
					2'd2: oe_ff <= 1'b0;
					default: begin
						st_ff <= pcb_pkg::HM_IDLE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						rdata_ff <= rx_ff;
						// track shutdown command writes
						if (wr_ff && !nack_ff && addr_ff == pcb_pkg::SHUT_OFF) begin
							if (wd_ff == pcb_pkg::SHUT_ALL) begin
								pdis_ff <= 1'b1;
							end else if (wd_ff == pcb_pkg::SHUT_NONE) begin
								pdis_ff <= 1'b0;
							end
						end
					end
					endcase
				end
			end
			endcase
		end
	end

	// outputs straight from flip-flops
	assign link.scl = scl_ff;
	assign link.host_sda_oe = oe_ff;
	assign busy = busy_ff;
	assign done = done_ff;
	assign nack = nack_ff;
	assign rdata = rdata_ff;
	assign ports_disabled = pdis_ff;
endmodule // pcb_host

// ==== sim/pcb_link_asserts.sv ====
`timescale 1ns/1ps
module pcb_link_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	// one clock domain, quiet during reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_idle_at_release: assert property ($rose(rst_n) |-> scl && sda)
		else $error("link not idle at reset release");
	a_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
		else $error("scl low phase too short");
	a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device moved sda while scl high");
	a_dev_bit_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
		else $error("device bit held too briefly");
	a_sda_after_rise: assert property ($rose(scl) |=> $stable(sda) [*6])
		else $error("sda moved just after scl rise");
	a_start_dev_quiet: assert property ($fell(sda) && scl |-> !dev_sda_oe)
		else $error("device drove sda at start");
	a_start_scl_hold: assert property ($fell(sda) && scl |=> scl [*4])
		else $error("scl fell too soon after start");
	a_stop_scl_idle: assert property ($rose(sda) && scl |=> scl [*8])
		else $error("scl moved after stop");
endmodule // pcb_link_asserts

// ==== sim/tb_poe_config_register_bank.sv ====
`timescale 1ns/1ps
module tb_poe_config_register_bank;
	logic sys_clk, rst_n, req, req_write, busy, done, nack, ports_disabled;
	logic [15:0] req_addr, req_wdata, rdata, total_power, ovl_timer_f;
	logic [15:0] ovl_timer_t, sync_type, event_sync, budget_active;
	logic [9:0] supply_level, supply_level_legacy;
	logic [2:0] power_good, op_mode;
	logic [5:0] ovl_timer_legacy;
	logic [11:0] class_calc, auto_calc;
	logic config_active, alloc_dynamic, alloc_ignore, pm_dynamic;
	logic legacy_cap_dis, ports_off, under_t, under_f, no_new_port;
	int n_mismatch, checked;
	pcb_link_if link();
	pcb_host u_pcb_host (.sys_clk, .rst_n, .link(link), .req, .req_write,
		.req_addr, .req_wdata, .busy, .done, .nack, .rdata, .ports_disabled);
	pcb_dev u_pcb_dev (.sys_clk, .rst_n, .link(link), .power_good,
		.supply_level, .supply_level_legacy, .total_power, .op_mode,
		.config_active, .ovl_timer_legacy, .ovl_timer_f, .ovl_timer_t,
		.sync_type, .event_sync, .budget_active, .alloc_dynamic,
		.alloc_ignore, .class_calc, .auto_calc, .pm_dynamic, .legacy_cap_dis,
		.ports_off, .under_t, .under_f, .no_new_port);
	pcb_link_asserts u_pcb_link_asserts (.sys_clk, .rst_n, .scl(link.scl),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
		.sda(link.sda));
	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// cut a hang short
	initial begin
		#300000;
		n_mismatch++;
		close_out();
	end
	task automatic close_out();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// one request, wait for done, en x skips the nack check
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [15:0] d, input logic en);
		int k;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req = 1'b1;
		tick(1);
		req = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 4000) begin
			tick(1);
			k++;
		end
		// a frame that never ends is a failure
		if (k >= 4000) begin
			n_mismatch++;
			$display("MISMATCH t=%0t no done from host", $time);
		end
		chk(16'(busy), 16'h0000);
		if (en !== 1'bx) begin
			chk(16'(nack), 16'(en));
		end
		// one idle edge before the next request
		tick(1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		xfer(1'b0, a, 16'h0000, 1'b0);
		chk(rdata, exp);
	endtask
	// key word followed by both mode syncs
	task automatic key(input logic [15:0] k);
		xfer(1'b1, pcb_pkg::KEY_OFF, k, 1'b0);
		xfer(1'b1, 16'h1318, pcb_pkg::SYNC_MODE, 1'b0);
		xfer(1'b1, 16'h1144, pcb_pkg::SYNC_MODE, 1'b0);
	endtask
	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		power_good = 3'h0;
		supply_level = 10'h350;
		supply_level_legacy = 10'h300;
		total_power = 16'h0000;
		n_mismatch = 0;
		checked = 0;
		tick(20);
		rst_n = 1'b1;
		chk(16'(op_mode), 16'h0003);
		chk(16'(ovl_timer_legacy), 16'h0020);
		chk(ovl_timer_t, 16'h0208);
		chk(budget_active, 16'h8700);
		chk(16'(alloc_ignore), 16'h0001);
		chk(16'(class_calc), 16'h0000);
		chk(16'(auto_calc), 16'h0FFF);
		chk(16'(legacy_cap_dis), 16'h0001);
		rd(pcb_pkg::KEY_OFF, 16'h0003);
		rd(16'h1010, 16'h0208);
		xfer(1'b0, 16'h138D, 16'h0000, 1'b1);
		for (int i = 0; i < 9; i++) begin
			xfer(1'b1, 16'h1318, 16'h0001 << i, 1'b0);
			chk(sync_type, 16'h0001 << i);
		end
		xfer(1'b1, pcb_pkg::SHUT_OFF, pcb_pkg::SHUT_NONE, 1'b0);
		chk(16'(ports_disabled), 16'h0000);
		xfer(1'b1, pcb_pkg::KEY_OFF, 16'hDC03, 1'b1);
		xfer(1'b1, pcb_pkg::SHUT_OFF, pcb_pkg::SHUT_ALL, 1'b0);
		chk(16'(ports_disabled), 16'h0001);
		key(16'hAB00);
		chk(16'(op_mode), 16'h0003);
		for (int m = 0; m < 4; m++) begin
			key({8'hDC, 8'(m)});
			rd(pcb_pkg::KEY_OFF, 16'(m));
			chk(16'(op_mode), 16'(m));
			chk(16'(config_active), 16'(m == 3));
			chk(event_sync, pcb_pkg::SYNC_MODE);
			if (m == 0) begin
				xfer(1'b1, 16'h100E, 16'h1234, 1'bx);
				rd(16'h100E, 16'h0208);
			end
		end
		xfer(1'b1, 16'h100E, 16'h1234, 1'b0);
		chk(ovl_timer_f, 16'h1234);
		xfer(1'b1, 16'h1160, 16'h0040, 1'b0);
		chk(16'({pm_dynamic, legacy_cap_dis}), 16'h0002);
		xfer(1'b1, 16'h0110, 16'h0FFF, 1'b0);
		chk(16'(alloc_dynamic), 16'h0001);
		power_good = 3'h3;
		supply_level_legacy = 10'h3E8;
		total_power = 16'h53E4;
		supply_level = 10'h312;
		tick(8);
		chk(budget_active, 16'h0898);
		chk(16'(ports_off), 16'h0001);
		chk(16'(no_new_port), 16'h0000);
		chk(16'({under_t, under_f}), 16'h0002);
		supply_level_legacy = 10'h3E7;
		total_power = 16'h53E5;
		supply_level = 10'h320;
		tick(4);
		chk(16'({ports_off, no_new_port, under_t}), 16'h0003);
		supply_level = 10'h324;
		tick(4);
		chk(16'(under_t), 16'h0000);
		close_out();
	end
endmodule // tb_poe_config_register_bank
